// file: src/umam_decoder.sv
// Unified address decoder and bus steering for the CPU and DMA requesters.
// ----------------------------------------------------------------------
// Summary of operation
// - Low 128 internal bytes direct; upper indirect only.
// - Special registers; multiples of eight bit-addressable.
// - Fetch and external data share one bus.
// - Flash decoded from zero to variant top.
// - SRAM populated from 0xF000 upward.
// - 0xFF00-0xFFFF aliases internal data bytes.
// - Radio window 0xDF00 to 0xDF3D.
// - I2S window 0xDF40 to 0xDF48.
// - Peripheral special registers at 0xDF80-0xDFFF.
// - CPU-internal registers absent from alias window.
// - USB window only on USB variant.
// - Program decode identical to data decode.
// - Writes to flash are dropped.
// - Variant SRAM holes are unimplemented.
// - Top 350 bytes volatile in deep modes on the 32 KB flash variant.
// - Register banks low; 0x20-0x2F bit-addressable.
// - No RAM clearing after power-on.
// - Flash fetches cached unless cache disabled.
// - 32 main pages plus information page.
// - Information page selected only by debug.
// - Flash erase and write durations.
// ----------------------------------------------------------------------
module umam_decoder
	import umam_pkg::*;
#(
	parameter int FLASH_KB = 32,
	parameter int SRAM_KB = 4,
	parameter bit HAS_USB = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire umam_req_t cpuReq,
	input wire logic cpuDirect,
	input wire umam_req_t dmaReq,
	input wire logic [127:0] sfrCoreMap,
	input wire logic icacheDisable,
	input wire logic debugInfoPage,
	input wire umam_rsp_t targetRsp,
	output umam_sel_t targetSel,
	output logic cpuGrant,
	output logic dmaGrant,
	output umam_rsp_t cpuRsp,
	output umam_rsp_t dmaRsp,
	output logic icacheBypass,
	output logic infoPageSel,
	output logic [5:0] flashPage
);

	// ----------------------------------------------------------------------
	// Variant derived bounds
	// ----------------------------------------------------------------------
	localparam logic [15:0] FLASH_TOP = (FLASH_KB == 8) ? FLASH_END_8K :
		(FLASH_KB == 16) ? FLASH_END_16K : FLASH_END_32K;
	localparam logic [15:0] SRAM_TOP = (SRAM_KB == 1) ? SRAM_HOLE_1K :
		(SRAM_KB == 2) ? SRAM_HOLE_2K : IDATA_BASE;
	localparam int PAGE_SHIFT = $clog2(FLASH_PAGE_BYTES);

	typedef struct packed {
		umam_arb_t arb;
		logic lastDma;
		umam_sel_t sel;
		umam_rsp_t cpuRsp;
		umam_rsp_t dmaRsp;
		logic cpuGrant;
		logic dmaGrant;
		logic icacheBypass;
		logic infoPageSel;
		logic [5:0] flashPage;
	} umam_state_t;

	umam_state_t state_reg;
	umam_state_t state_next;

	// ----------------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------------
	function automatic umam_target_t decode(input logic [15:0] a, input logic [127:0] coreMap);
		umam_target_t t;
		t = TGT_NONE;
		if (a <= FLASH_TOP) begin
			t = TGT_FLASH;
		end else if (HAS_USB && a >= USB_BASE && a <= USB_END) begin
			t = TGT_USB;
		end else if (a >= RADIO_BASE && a <= RADIO_END) begin
			t = TGT_RADIO;
		end else if (a >= I2S_BASE && a <= I2S_END) begin
			t = TGT_I2S;
		end else if (a >= SFR_BASE && a <= SFR_END) begin
			t = coreMap[a[6:0]] ? TGT_NONE : TGT_SFR;
		end else if (a >= SRAM_BASE && a < SRAM_TOP) begin
			t = TGT_SRAM;
		end else if (a >= IDATA_BASE) begin
			t = TGT_IDATA;
		end
		return t;
	endfunction : decode

	function automatic logic isRetained(input logic [15:0] a);
		return !(FLASH_KB == 32 && a >= VOLATILE_BASE && a <= VOLATILE_END);
	endfunction : isRetained

	function automatic logic isBitByte(input umam_target_t t, input logic [15:0] a);
		logic r;
		r = 1'b0;
		if (t == TGT_IDATA) begin
			r = a[7:0] >= BITBYTE_LO && a[7:0] <= BITBYTE_HI;
		end else if (t == TGT_SFR) begin
			r = a[2:0] == SFR_BITADDR_MASK;
		end
		return r;
	endfunction : isBitByte

	// ----------------------------------------------------------------------
	// Arbitration and steering
	// ----------------------------------------------------------------------
	always_comb begin
		umam_req_t req;
		umam_target_t tgt;
		logic blocked;
		req = '0;
		tgt = TGT_NONE;
		blocked = 1'b0;
		state_next = state_reg;
		state_next.cpuGrant = 1'b0;
		state_next.dmaGrant = 1'b0;
		state_next.sel.valid = 1'b0;
		state_next.cpuRsp = '0;
		state_next.dmaRsp = '0;
		state_next.icacheBypass = icacheDisable;
		state_next.infoPageSel = debugInfoPage;
		case (state_reg.arb)
			ARB_IDLE: begin
				if (dmaReq.valid && (!cpuReq.valid || !state_reg.lastDma)) begin
					state_next.arb = ARB_DMA;
					state_next.dmaGrant = 1'b1;
					state_next.lastDma = 1'b1;
					req = dmaReq;
				end else if (cpuReq.valid) begin
					state_next.arb = ARB_CPU;
					state_next.cpuGrant = 1'b1;
					state_next.lastDma = 1'b0;
					req = cpuReq;
				end
				if (state_next.arb != ARB_IDLE) begin
					tgt = decode(req.addr, sfrCoreMap);
					if (state_next.arb == ARB_CPU && cpuDirect && tgt == TGT_IDATA &&
						req.addr[7:0] > IDATA_DIRECT_TOP) begin
						tgt = TGT_NONE;
					end
					blocked = req.write && tgt == TGT_FLASH;
					state_next.sel.valid = 1'b1;
					state_next.sel.write = req.write && !blocked;
					state_next.sel.owner = state_next.arb == ARB_DMA;
					state_next.sel.target = tgt;
					state_next.sel.offset = req.addr;
					state_next.sel.wdata = req.wdata;
					state_next.sel.retained = isRetained(req.addr);
					state_next.sel.bitAddressable = isBitByte(tgt, req.addr);
					state_next.icacheBypass = icacheDisable || !(req.fetch && tgt == TGT_FLASH);
					state_next.flashPage = 6'(req.addr >> PAGE_SHIFT);
				end
			end
			ARB_CPU, ARB_DMA: begin
				if (targetRsp.valid) begin
					if (state_reg.arb == ARB_CPU) begin
						state_next.cpuRsp = targetRsp;
						state_next.cpuRsp.fault = targetRsp.fault || state_reg.sel.target == TGT_NONE;
					end else begin
						state_next.dmaRsp = targetRsp;
						state_next.dmaRsp.fault = targetRsp.fault || state_reg.sel.target == TGT_NONE;
					end
					state_next.arb = ARB_IDLE;
				end
			end
			default: begin
				state_next.arb = ARB_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------------
	// Storage contents are not cleared here; only control state resets.
	// No RAM initialise.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= '0;
			state_reg.arb <= ARB_IDLE;
			state_reg.sel.target <= TGT_NONE;
			state_reg.icacheBypass <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign infoPageSel = state_reg.infoPageSel;
	assign targetSel = state_reg.sel;
	assign cpuGrant = state_reg.cpuGrant;
	assign dmaGrant = state_reg.dmaGrant;
	assign cpuRsp = state_reg.cpuRsp;
	assign dmaRsp = state_reg.dmaRsp;
	assign icacheBypass = state_reg.icacheBypass;
	assign flashPage = state_reg.flashPage;

	// Flash durations are owned by the flash controller; constants sit in the package.

endmodule : umam_decoder

// file: src/umam_pkg.sv
// Package of the unified memory address map: address bounds, variants, ports and timing.
package umam_pkg;

	// ----------------------------------------------------------------------
	// Unified address bounds
	// ----------------------------------------------------------------------
	localparam logic [15:0] FLASH_BASE = 16'h0000;
	localparam logic [15:0] FLASH_END_8K = 16'h1fff;
	localparam logic [15:0] FLASH_END_16K = 16'h3fff;
	localparam logic [15:0] FLASH_END_32K = 16'h7fff;
	localparam logic [15:0] USB_BASE = 16'hde00;
	localparam logic [15:0] USB_END = 16'hde3f;
	localparam logic [15:0] RADIO_BASE = 16'hdf00;
	localparam logic [15:0] RADIO_END = 16'hdf3d;
	localparam logic [15:0] I2S_BASE = 16'hdf40;
	localparam logic [15:0] I2S_END = 16'hdf48;
	localparam logic [15:0] SFR_BASE = 16'hdf80;
	localparam logic [15:0] SFR_END = 16'hdfff;
	localparam logic [15:0] SRAM_BASE = 16'hf000;
	localparam logic [15:0] SRAM_HOLE_1K = 16'hf300;
	localparam logic [15:0] SRAM_HOLE_2K = 16'hf700;
	localparam logic [15:0] SRAM_HOLE_END = 16'hfeff;
	localparam logic [15:0] VOLATILE_BASE = 16'hfda2;
	localparam logic [15:0] VOLATILE_END = 16'hfeff;
	localparam logic [15:0] VOLATILE_BYTES = 16'h015e;
	localparam logic [15:0] IDATA_BASE = 16'hff00;
	localparam logic [15:0] IDATA_END = 16'hffff;

	// ----------------------------------------------------------------------
	// Internal data and special register layout
	// ----------------------------------------------------------------------
	localparam logic [7:0] IDATA_DIRECT_TOP = 8'h7f;
	localparam logic [7:0] BITBYTE_LO = 8'h20;
	localparam logic [7:0] BITBYTE_HI = 8'h2f;
	localparam logic [7:0] REGBANK_TOP = 8'h1f;
	localparam logic [2:0] SFR_BITADDR_MASK = 3'h0;
	localparam int FLASH_PAGES_MAX = 32;
	localparam int FLASH_PAGE_BYTES = 1024;
	localparam int XDATA_CYCLES_MIN = 4;
	localparam int XDATA_CYCLES_MAX = 5;

	// ----------------------------------------------------------------------
	// Flash timing
	// ----------------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int PAGE_ERASE_MS = 20;
	localparam int MASS_ERASE_MS = 200;
	localparam int WORD_WRITE_US = 20;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_MS * 1000 * CLK_MHZ;
	localparam int MASS_ERASE_CYC = MASS_ERASE_MS * 1000 * CLK_MHZ;
	localparam int WORD_WRITE_CYC = WORD_WRITE_US * CLK_MHZ;

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef enum logic [7:0] {
		TGT_NONE = 8'h01,
		TGT_FLASH = 8'h02,
		TGT_SRAM = 8'h04,
		TGT_IDATA = 8'h08,
		TGT_RADIO = 8'h10,
		TGT_I2S = 8'h20,
		TGT_USB = 8'h40,
		TGT_SFR = 8'h80
	} umam_target_t;

	typedef enum logic [2:0] {
		ARB_IDLE = 3'h1,
		ARB_CPU = 3'h2,
		ARB_DMA = 3'h4
	} umam_arb_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic fetch;
		logic [15:0] addr;
		logic [7:0] wdata;
	} umam_req_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic owner;
		umam_target_t target;
		logic [15:0] offset;
		logic [7:0] wdata;
		logic retained;
		logic bitAddressable;
	} umam_sel_t;

	typedef struct packed {
		logic valid;
		logic fault;
		logic [7:0] rdata;
	} umam_rsp_t;

endpackage : umam_pkg

// file: test/umam_decoder_properties.sv
// Concurrent checks on the ports of the unified address decoder.
module umam_decoder_properties
	import umam_pkg::*;
#(
	parameter int FLASH_KB = 32,
	parameter int SRAM_KB = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire umam_req_t cpuReq,
	input wire logic cpuDirect,
	input wire umam_req_t dmaReq,
	input wire logic debugInfoPage,
	input wire umam_rsp_t targetRsp,
	input wire umam_sel_t targetSel,
	input wire logic cpuGrant,
	input wire logic dmaGrant,
	input wire umam_rsp_t cpuRsp,
	input wire umam_rsp_t dmaRsp,
	input wire logic infoPageSel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// First address of the unimplemented gap below the internal data alias; empty on the largest variant.
	localparam logic [15:0] HOLE_LO = (SRAM_KB == 1) ? SRAM_HOLE_1K : (SRAM_KB == 2) ? SRAM_HOLE_2K : IDATA_BASE;
	sequence s_cpu_win;
		cpuGrant && !cpuDirect;
	endsequence
	property p_onehot; targetSel.valid |-> $onehot(targetSel.target); endproperty
	a_onehot: assert property (p_onehot) else $error("target not one-hot");
	property p_grant; (cpuGrant || dmaGrant) == targetSel.valid; endproperty
	a_grant: assert property (p_grant) else $error("grant and select apart");
	property p_excl; !(cpuGrant && dmaGrant); endproperty
	a_excl: assert property (p_excl) else $error("two grants");
	property p_nowr; targetSel.valid && targetSel.target == TGT_FLASH |-> !targetSel.write; endproperty
	a_nowr: assert property (p_nowr) else $error("flash write passed");
	property p_rsp; targetRsp.valid |=> cpuRsp.valid != dmaRsp.valid; endproperty
	a_rsp: assert property (p_rsp) else $error("answer not routed");
	property p_flash; s_cpu_win |-> cpuReq.addr >= FLASH_KB * 1024 || targetSel.target == TGT_FLASH; endproperty
	a_flash: assert property (p_flash) else $error("flash decode");
	property p_alias; s_cpu_win |-> cpuReq.addr < IDATA_BASE || targetSel.target == TGT_IDATA; endproperty
	a_alias: assert property (p_alias) else $error("alias decode");
	property p_radio; dmaGrant && dmaReq.addr inside {[RADIO_BASE:RADIO_END]} |-> targetSel.target == TGT_RADIO;
	endproperty
	a_radio: assert property (p_radio) else $error("radio decode");
	property p_i2s; dmaGrant && dmaReq.addr inside {[I2S_BASE:I2S_END]} |-> targetSel.target == TGT_I2S; endproperty
	a_i2s: assert property (p_i2s) else $error("audio decode");
	property p_info; $past(rstn) |-> infoPageSel == $past(debugInfoPage); endproperty
	a_info: assert property (p_info) else $error("info page select");
	property p_hole;
		s_cpu_win |-> cpuReq.addr < HOLE_LO || cpuReq.addr > SRAM_HOLE_END || targetSel.target == TGT_NONE;
	endproperty
	a_hole: assert property (p_hole) else $error("memory gap decoded");
endmodule : umam_decoder_properties
bind umam_decoder umam_decoder_properties #(.FLASH_KB(FLASH_KB), .SRAM_KB(SRAM_KB)) umam_decoder_properties_i (
	.clk(clk), .rstn(rstn), .cpuReq(cpuReq), .cpuDirect(cpuDirect), .dmaReq(dmaReq),
	.debugInfoPage(debugInfoPage), .targetRsp(targetRsp), .targetSel(targetSel), .cpuGrant(cpuGrant),
	.dmaGrant(dmaGrant), .cpuRsp(cpuRsp), .dmaRsp(dmaRsp), .infoPageSel(infoPageSel)
);

// file: test/umam_target_model.sv
// Behavioural target side that answers each selected access after a chosen lag.
module umam_target_model
	import umam_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire umam_sel_t sel,
	input wire logic [1:0] lag,
	output umam_rsp_t rsp
);
	logic busy;
	logic [1:0] cnt;
	logic [7:0] hold;
	// Idle read data toggles every cycle so that a stale byte is never mistaken for an answer.
	always @(posedge clk) begin
		rsp.valid <= 1'b0;
		rsp.fault <= 1'b0;
		rsp.rdata <= ~rsp.rdata;
		if (!rstn) begin
			busy <= 1'b0;
			rsp <= '0;
		end else if (sel.valid) begin
			busy <= 1'b1;
			cnt <= lag;
			hold <= sel.target;
		end else if (busy && cnt == 2'h0) begin
			busy <= 1'b0;
			rsp.valid <= 1'b1;
			rsp.rdata <= hold;
		end else if (busy) begin
			cnt <= cnt - 2'h1;
		end
	end
endmodule : umam_target_model

// file: test/unified_memory_address_map_tb.sv
// Self-checking bench for the unified address decoder.
module unified_memory_address_map_tb
	import umam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FK = 16;
	localparam int SK = 2;
	// End of populated SRAM below the internal data alias for the chosen SRAM size.
	localparam logic [15:0] SRAM_LIM = (SK == 1) ? SRAM_HOLE_1K : (SK == 2) ? SRAM_HOLE_2K : IDATA_BASE;
	logic clk = 0;
	logic rstn = 0;
	logic cpuDirect = 0;
	logic icacheDisable = 0;
	logic debugInfoPage = 0;
	logic [1:0] lag = 0;
	logic [127:0] sfrCoreMap = '0;
	umam_req_t cpuReq = '0;
	umam_req_t dmaReq = '0;
	umam_rsp_t targetRsp, cpuRsp, dmaRsp;
	umam_sel_t targetSel;
	logic cpuGrant, dmaGrant, icacheBypass, infoPageSel;
	logic [5:0] flashPage;
	logic solo = 1;
	logic icacheDisPrev = 0;
	int fails = 0;
	int comparisons = 0;
	int seed;
	logic [15:0] corner [21] = '{16'h0000, 16'h3fff, 16'h4000, 16'hde00, 16'hdf00, 16'hdf3d, 16'hdf3e, 16'hdf40,
		16'hdf48, 16'hdf80, 16'hdf88, 16'hdfff, 16'hf000, 16'hf6ff, 16'hf700, 16'hf7ff, 16'hf800, 16'hfeff,
		16'hff00, 16'hff24, 16'hffff};
	umam_decoder #(.FLASH_KB(FK), .SRAM_KB(SK), .HAS_USB(1'b0)) umam_decoder_i (.clk(clk), .rstn(rstn),
		.cpuReq(cpuReq), .cpuDirect(cpuDirect), .dmaReq(dmaReq), .sfrCoreMap(sfrCoreMap),
		.icacheDisable(icacheDisable), .debugInfoPage(debugInfoPage), .targetRsp(targetRsp),
		.targetSel(targetSel), .cpuGrant(cpuGrant), .dmaGrant(dmaGrant), .cpuRsp(cpuRsp), .dmaRsp(dmaRsp),
		.icacheBypass(icacheBypass), .infoPageSel(infoPageSel), .flashPage(flashPage));
	umam_target_model umam_target_model_i (.clk(clk), .rstn(rstn), .sel(targetSel), .lag(lag), .rsp(targetRsp));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		lag <= 2'($urandom);
		debugInfoPage <= 1'($urandom);
		icacheDisable <= 1'($urandom);
		// The decoder registers the cache control at the take edge, one edge before the grant is seen.
		icacheDisPrev <= icacheDisable;
	end
	function automatic umam_target_t exp_tgt(logic [15:0] a, logic d);
		if (d) return a[7] ? TGT_NONE : TGT_IDATA;
		if (a >= IDATA_BASE) return TGT_IDATA;
		if (a < FK * 1024) return TGT_FLASH;
		if (a >= SRAM_BASE) return (a < SRAM_LIM) ? TGT_SRAM : TGT_NONE;
		if (a inside {[RADIO_BASE:RADIO_END]}) return TGT_RADIO;
		if (a inside {[I2S_BASE:I2S_END]}) return TGT_I2S;
		if (a >= SFR_BASE && a <= SFR_END) return sfrCoreMap[a[6:0]] ? TGT_NONE : TGT_SFR;
		return TGT_NONE;
	endfunction : exp_tgt
	function automatic logic exp_bit(umam_target_t t, logic [15:0] a);
		if (t == TGT_IDATA) return a[7:0] inside {[BITBYTE_LO:BITBYTE_HI]};
		return t == TGT_SFR && a[2:0] == 3'h0;
	endfunction : exp_bit
	task automatic close_out;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic give_up;
		fails++;
		$display("FAIL wait exp done got none");
		close_out();
	endtask : give_up
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic acc(logic dma, logic w, logic f, logic d, logic [15:0] a);
		umam_req_t r;
		umam_target_t e;
		int n;
		r = '{1'b1, w, f, a, 8'($urandom)};
		e = exp_tgt(a, d);
		if (dma) dmaReq <= r;
		else begin
			cpuReq <= r;
			cpuDirect <= d;
		end
		for (n = 0; (dma ? dmaGrant : cpuGrant) !== 1'b1; n++) begin
			if (n == 40) give_up();
			@(posedge clk);
		end
		chk("target", e, targetSel.target);
		chk("write", w && e != TGT_FLASH, targetSel.write);
		chk("wdata", r.wdata, targetSel.wdata);
		chk("offset", a, targetSel.offset);
		chk("owner", dma, targetSel.owner);
		chk("bitaddr", exp_bit(e, a), targetSel.bitAddressable);
		chk("retained", !(FK == 32 && a inside {[VOLATILE_BASE:VOLATILE_END]}), targetSel.retained);
		chk("bypass", icacheDisPrev || !(f && e == TGT_FLASH), icacheBypass);
		if (dma) dmaReq.valid <= 1'b0;
		else cpuReq.valid <= 1'b0;
		for (n = 0; (dma ? dmaRsp.valid : cpuRsp.valid) !== 1'b1; n++) begin
			if (n == 40) give_up();
			@(posedge clk);
		end
		chk("fault", e == TGT_NONE, dma ? dmaRsp.fault : cpuRsp.fault);
		if (e != TGT_NONE) chk("rdata", e, dma ? dmaRsp.rdata : cpuRsp.rdata);
		if (solo) chk("page", a[15:10], flashPage);
	endtask : acc
	initial begin
		seed = $urandom(32'h097d);
		sfrCoreMap <= {$urandom, $urandom, $urandom, $urandom};
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		foreach (corner[i]) acc(i[0], 1'($urandom), 1'($urandom), 1'b0, corner[i]);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 16'h0010);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 16'hff7f);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 16'hff80);
		repeat (80) acc(1'($urandom), 1'($urandom), 1'($urandom), 1'b0, 16'($urandom));
		solo = 1'b0;
		repeat (10) fork
			acc(1'b0, 1'($urandom), 1'($urandom), 1'b0, 16'($urandom));
			acc(1'b1, 1'($urandom), 1'b0, 1'b0, 16'($urandom));
		join
		close_out();
	end
endmodule : unified_memory_address_map_tb
